// *** cpu_bus_model.sv ***
// Purpose: processor side of the peripheral bus, one access per call
// Assumes: calls start at a falling edge of mclk
// Notes:   released address and data lines show inverted values; per_wr and per_byte keep their stale ones

`timescale 1ns/1ps

module cpu_bus_model (
  // clock
  input  wire logic        mclk,
  // peripheral bus
  output logic             per_sel,
  output logic             per_wr,
  output logic             per_byte,
  output logic      [15:0] per_addr,
  output logic      [15:0] per_wdata,
  input  wire logic [15:0] per_rdata
);
  initial begin
    per_sel   = 1'b0;
    per_wr    = 1'b0;
    per_byte  = 1'b0;
    per_addr  = 16'h0000;
    per_wdata = 16'h0000;
  end

  // ----------------------------------------------------------------------
  // accesses
  // ----------------------------------------------------------------------
  // word or byte
  // select is left high so the caller can go back to back
  task automatic acc(input logic w, input logic b, input logic [15:0] a,
                     input logic [15:0] d);
    per_sel   <= 1'b1;
    per_wr    <= w;
    per_byte  <= b;
    per_addr  <= a;
    per_wdata <= d;
    @(negedge mclk);
  endtask : acc

  task automatic wr(input logic b, input logic [15:0] a, input logic [15:0] d);
    acc(1'b1, b, a, d);
  endtask : wr

  task automatic rd(input logic b, input logic [15:0] a,
                    output logic [15:0] d);
    acc(1'b0, b, a, ~per_wdata);
    d = per_rdata;
  endtask : rd

  task automatic idle;
    per_sel   <= 1'b0;
    per_addr  <= ~per_addr;
    per_wdata <= ~per_wdata;
    @(negedge mclk);
  endtask : idle
endmodule : cpu_bus_model

// *** mac_pkg.sv ***
// Purpose: shared constants for the memory mapped multiply accumulate unit
// Assumes: 16-bit peripheral data bus, byte addresses, word aligned registers
// Notes:   operand and result registers carry no reset value

package mac_pkg;

  // ----------------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------------
  localparam logic [15:0] BLOCK_BASE  = 16'h0130;
  localparam logic [15:0] BLOCK_MASK  = 16'hfff0;
  localparam logic [15:0] OFS_MPY     = 16'h0130;
  localparam logic [15:0] OFS_SIGNED_PRODUCT_FIRST_OPERAND    = 16'h0132;
  localparam logic [15:0] OFS_MAC     = 16'h0134;
  localparam logic [15:0] OFS_SIGNED_ACCUMULATE_FIRST_OPERAND    = 16'h0136;
  localparam logic [15:0] OFS_SECOND  = 16'h0138;
  localparam logic [15:0] OFS_RES_LO  = 16'h013a;
  localparam logic [15:0] OFS_RES_HI  = 16'h013c;
  localparam logic [15:0] OFS_SUM_EXT = 16'h013e;

  // word index within the block, taken from address bits 3:1
  localparam logic [2:0] IDX_SECOND  = 3'h4;
  localparam logic [2:0] IDX_RES_LO  = 3'h5;
  localparam logic [2:0] IDX_RES_HI  = 3'h6;
  localparam logic [2:0] IDX_SUM_EXT = 3'h7;

  // ----------------------------------------------------------------------
  // field layout and values
  // ----------------------------------------------------------------------
  localparam int          IDX_LSB    = 1;
  localparam int          IDX_MSB    = 3;
  localparam int          MODE_LSB   = 1;
  localparam int          MODE_MSB   = 2;
  localparam logic [15:0] EXT_ZERO   = 16'h0000;
  localparam logic [15:0] EXT_ONE    = 16'h0001;
  localparam logic [15:0] EXT_ONES   = 16'hffff;
  localparam logic [15:0] RDATA_RST  = 16'h0000;

  // operation type, encoded as the alias address bits 2:1
  typedef enum logic [1:0] {
    unsigned_product_mode    = 2'h0,
    signed_product_mode      = 2'h1,
    unsigned_accumulate_mode = 2'h2,
    signed_accumulate_mode   = 2'h3
  } mode_t;

  localparam mode_t MODE_RST = unsigned_product_mode;

endpackage : mac_pkg

// *** mem_mac.sv ***
// Purpose: 16x16 multiply and accumulate peripheral on the processor bus
// Assumes: one access per cycle; read data appears the cycle after the access
// Notes:   the multiply is combinational into the result words, so no wait

`timescale 1ns/1ps

module mem_mac (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // peripheral bus
  input  wire logic        per_sel,
  input  wire logic        per_wr,
  input  wire logic        per_byte,
  input  wire logic [15:0] per_addr,
  input  wire logic [15:0] per_wdata,
  output logic      [15:0] per_rdata
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  // operand and result words
  logic [15:0]    first_operand_r;
  logic [15:0]    first_operand_nxt;
  logic [15:0]    second_operand_r;
  logic [15:0]    second_operand_nxt;
  logic [15:0]    result_low_word_r;
  logic [15:0]    result_low_word_nxt;
  logic [15:0]    result_high_word_r;
  logic [15:0]    result_high_word_nxt;
  logic [15:0]    sum_extension_r;
  logic [15:0]    sum_extension_nxt;
  mac_pkg::mode_t mode_r;
  mac_pkg::mode_t mode_nxt;
  logic [15:0]    rdata_r;
  logic [15:0]    rdata_nxt;
  // checker helper: set by the first operand write, never cleared, so the
  // reset check stays quiet while the operand is still unwritten
  logic           op_loaded_r;
  logic           op_loaded_nxt;

  logic        hit;
  logic        wr_hit;
  logic        rd_hit;
  logic [2:0]  idx;
  logic        trigger;
  logic [15:0] op2_val;
  logic [31:0] product;
  logic [31:0] acc_val;
  logic [32:0] acc_sum;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // merge a bus write into a word register: byte writes at an even address
  // zero the high byte, at an odd address they replace the high byte only
  function automatic logic [15:0] merge_write(
    input logic [15:0] old_val,
    input logic [15:0] wdata,
    input logic        is_byte,
    input logic        odd
  );
    logic [15:0] res;
    res = wdata;
    if (is_byte && !odd) begin
      res = {8'h00, wdata[7:0]};
    end else if (is_byte) begin
      res = {wdata[7:0], old_val[7:0]};
    end
    return res;
  endfunction : merge_write

  // 16x16 multiply; signed operands are sign-extended before the multiply
  function automatic logic [31:0] mul16(
    input logic [15:0] a,
    input logic [15:0] b,
    input logic        sgn
  );
    logic [31:0] ax;
    logic [31:0] bx;
    logic [63:0] full;
    ax   = {{16{sgn & a[15]}}, a};
    bx   = {{16{sgn & b[15]}}, b};
    full = ax * bx;
    return full[31:0];
  endfunction : mul16

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  assign hit    = per_sel && ((per_addr & mac_pkg::BLOCK_MASK)
                              == mac_pkg::BLOCK_BASE);
  assign wr_hit = hit && per_wr;
  assign rd_hit = hit && !per_wr;
  assign idx    = per_addr[mac_pkg::IDX_MSB:mac_pkg::IDX_LSB];

  assign trigger = wr_hit && (idx == mac_pkg::IDX_SECOND);

  assign op2_val = merge_write(second_operand_r, per_wdata, per_byte,
                               per_addr[0]);

  assign product = mul16(first_operand_r, op2_val,
                         (mode_r == mac_pkg::signed_product_mode) ||
                         (mode_r == mac_pkg::signed_accumulate_mode));

  assign acc_val = {result_high_word_r, result_low_word_r};
  assign acc_sum = {1'b0, acc_val} + {1'b0, product};

  // ----------------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------------
  always_comb begin
    first_operand_nxt    = first_operand_r;
    second_operand_nxt   = second_operand_r;
    result_low_word_nxt  = result_low_word_r;
    result_high_word_nxt = result_high_word_r;
    sum_extension_nxt    = sum_extension_r;
    mode_nxt             = mode_r;
    op_loaded_nxt        = op_loaded_r;
    if (wr_hit && !idx[2]) begin
      first_operand_nxt = merge_write(first_operand_r, per_wdata, per_byte,
                                      per_addr[0]);
      mode_nxt = mac_pkg::mode_t'(
                   per_addr[mac_pkg::MODE_MSB:mac_pkg::MODE_LSB]);
      op_loaded_nxt = 1'b1;
    end
    if (trigger) begin
      second_operand_nxt = op2_val;
      unique case (mode_r)
        mac_pkg::unsigned_product_mode: begin
          result_low_word_nxt  = product[15:0];
          result_high_word_nxt = product[31:16];
          sum_extension_nxt    = mac_pkg::EXT_ZERO;
        end
        mac_pkg::signed_product_mode: begin
          result_low_word_nxt  = product[15:0];
          result_high_word_nxt = product[31:16];
          sum_extension_nxt    = product[31] ? mac_pkg::EXT_ONES
                                             : mac_pkg::EXT_ZERO;
        end
        mac_pkg::unsigned_accumulate_mode: begin
          result_low_word_nxt  = acc_sum[15:0];
          result_high_word_nxt = acc_sum[31:16];
          sum_extension_nxt    = acc_sum[32] ? mac_pkg::EXT_ONE
                                             : mac_pkg::EXT_ZERO;
        end
        mac_pkg::signed_accumulate_mode: begin
          result_low_word_nxt  = acc_sum[15:0];
          result_high_word_nxt = acc_sum[31:16];
          sum_extension_nxt    = acc_sum[31] ? mac_pkg::EXT_ONES
                                             : mac_pkg::EXT_ZERO;
        end
      endcase
    end
    if (wr_hit && (idx == mac_pkg::IDX_RES_LO)) begin
      result_low_word_nxt = merge_write(result_low_word_r, per_wdata,
                                        per_byte, per_addr[0]);
    end
    if (wr_hit && (idx == mac_pkg::IDX_RES_HI)) begin
      result_high_word_nxt = merge_write(result_high_word_r, per_wdata,
                                         per_byte, per_addr[0]);
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  always_comb begin
    logic [15:0] word;
    word      = mac_pkg::EXT_ZERO;
    rdata_nxt = rdata_r;
    unique case (idx)
      mac_pkg::IDX_SECOND:  word = second_operand_r;
      mac_pkg::IDX_RES_LO:  word = result_low_word_r;
      mac_pkg::IDX_RES_HI:  word = result_high_word_r;
      mac_pkg::IDX_SUM_EXT: word = sum_extension_r;
      default:              word = first_operand_r;
    endcase
    if (rd_hit) begin
      if (per_byte) begin
        rdata_nxt = per_addr[0] ? {8'h00, word[15:8]} : {8'h00, word[7:0]};
      end else begin
        rdata_nxt = word;
      end
    end else if (per_sel) begin
      rdata_nxt = mac_pkg::RDATA_RST;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // operands and results untouched by reset
  always_ff @(posedge mclk) begin
    first_operand_r    <= first_operand_nxt;
    second_operand_r   <= second_operand_nxt;
    result_low_word_r  <= result_low_word_nxt;
    result_high_word_r <= result_high_word_nxt;
    sum_extension_r    <= sum_extension_nxt;
    op_loaded_r        <= op_loaded_nxt;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_r  <= mac_pkg::MODE_RST;
      rdata_r <= mac_pkg::RDATA_RST;
    end else begin
      mode_r  <= mode_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign per_rdata = rdata_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_MPY_RESULT: assert property (
    @(posedge mclk) disable iff (sys_rst)
    trigger && !per_byte && (mode_r == mac_pkg::unsigned_product_mode)
    |=> {result_high_word_r, result_low_word_r} ==
        ({16'h0000, $past(first_operand_r)} * {16'h0000, $past(per_wdata)}))
    else $error("unsigned product wrong after trigger");

  AST_MPY_EXT: assert property (
    @(posedge mclk) disable iff (sys_rst)
    trigger && (mode_r == mac_pkg::unsigned_product_mode)
    |=> sum_extension_r == mac_pkg::EXT_ZERO)
    else $error("unsigned extension not zero");

  AST_SIGNED_PRODUCT_FIRST_OPERAND_SIGN: assert property (
    @(posedge mclk) disable iff (sys_rst)
    trigger && (mode_r == mac_pkg::signed_product_mode)
    |=> sum_extension_r == {16{result_high_word_r[15]}})
    else $error("signed extension does not follow sign");

  AST_MAC_CARRY: assert property (
    @(posedge mclk) disable iff (sys_rst)
    trigger && (mode_r == mac_pkg::unsigned_accumulate_mode)
    |=> sum_extension_r == {15'h0000,
          ({result_high_word_r, result_low_word_r} < $past(acc_val))})
    else $error("accumulate carry wrong");

  AST_SIGNED_ACCUMULATE_FIRST_OPERAND_WRAP: assert property (
    @(posedge mclk) disable iff (sys_rst)
    trigger && (mode_r == mac_pkg::signed_accumulate_mode)
    |=> sum_extension_r == {16{result_high_word_r[15]}})
    else $error("signed accumulate extension wrong");

  AST_MODE_LATCH: assert property (
    @(posedge mclk) disable iff (sys_rst)
    wr_hit && !idx[2] |=> mode_r == $past(per_addr[2:1]))
    else $error("mode not taken from alias address");

  AST_MODE_HOLD: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !(wr_hit && !idx[2]) |=> $stable(mode_r))
    else $error("mode changed without operand write");

  AST_BYTE_CLEAR: assert property (
    @(posedge mclk) disable iff (sys_rst)
    wr_hit && !idx[2] && per_byte && !per_addr[0]
    |=> first_operand_r == {8'h00, $past(per_wdata[7:0])})
    else $error("byte operand write not zero-extended");

  AST_READ_LO: assert property (
    @(posedge mclk) disable iff (sys_rst)
    rd_hit && !per_byte && (idx == mac_pkg::IDX_RES_LO)
    |=> per_rdata == $past(result_low_word_r))
    else $error("low result read wrong");

  AST_OPS_RESET: assert property (@(posedge mclk)
    sys_rst && op_loaded_r && !wr_hit |=> $stable(first_operand_r))
    else $error("reset altered operand");

  AST_RES_HI_WRITE: assert property (
    @(posedge mclk) disable iff (sys_rst)
    wr_hit && !per_byte && (idx == mac_pkg::IDX_RES_HI)
    |=> result_high_word_r == $past(per_wdata))
    else $error("result high word write lost");

  COV_SIGNED_PRODUCT_FIRST_OPERAND: cover property (@(posedge mclk) disable iff (sys_rst)
    trigger && (mode_r == mac_pkg::signed_product_mode));
  COV_MAC_CARRY: cover property (@(posedge mclk) disable iff (sys_rst)
    trigger && (mode_r == mac_pkg::unsigned_accumulate_mode) ##1
    (sum_extension_r == mac_pkg::EXT_ONE));
  COV_SIGNED_ACCUMULATE_FIRST_OPERAND: cover property (@(posedge mclk) disable iff (sys_rst)
    trigger && (mode_r == mac_pkg::signed_accumulate_mode));
  COV_BACK_TO_BACK: cover property (@(posedge mclk) disable iff (sys_rst)
    trigger ##1 trigger);

endmodule : mem_mac

// *** memory_mapped_multiply_accumulate_tb_top.sv ***
// Purpose: self-checking bench for the multiply accumulate peripheral
// Assumes: bus model drives at falling edges, reads are one cycle late
// Notes:   expected products are worked out by hand

`timescale 1ns/1ps

module memory_mapped_multiply_accumulate_tb_top;
  logic        mclk;
  logic        sys_rst;
  logic        per_sel;
  logic        per_wr;
  logic        per_byte;
  logic [15:0] per_addr;
  logic [15:0] per_wdata;
  logic [15:0] per_rdata;
  int          n_errors;
  int          check_count;
  int          cycles;

  mem_mac u_dut (.mclk(mclk), .sys_rst(sys_rst), .per_sel(per_sel),
    .per_wr(per_wr), .per_byte(per_byte), .per_addr(per_addr),
    .per_wdata(per_wdata), .per_rdata(per_rdata));

  cpu_bus_model u_cpu (.mclk(mclk), .per_sel(per_sel), .per_wr(per_wr),
    .per_byte(per_byte), .per_addr(per_addr), .per_wdata(per_wdata),
    .per_rdata(per_rdata));

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // ----------------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rc(input logic b, input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    u_cpu.rd(b, a, d);
    check(d, e);
  endtask : rc

  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_unsigned;
    u_cpu.wr(1'b0, mac_pkg::OFS_MPY, 16'h1234);
    u_cpu.wr(1'b0, mac_pkg::OFS_SECOND, 16'h5678);
    rc(1'b0, mac_pkg::OFS_RES_LO, 16'h0060);
    rc(1'b0, mac_pkg::OFS_RES_HI, 16'h0626);
    rc(1'b0, mac_pkg::OFS_SUM_EXT, 16'h0000);
    u_cpu.idle();
  endtask : t_unsigned

  task automatic t_signed;
    u_cpu.wr(1'b0, mac_pkg::OFS_SIGNED_PRODUCT_FIRST_OPERAND, 16'hfffe);
    u_cpu.wr(1'b0, mac_pkg::OFS_SECOND, 16'h0003);
    rc(1'b0, mac_pkg::OFS_RES_LO, 16'hfffa);
    rc(1'b0, mac_pkg::OFS_SUM_EXT, 16'hffff);
    u_cpu.wr(1'b0, mac_pkg::OFS_SECOND, 16'hfffd);
    rc(1'b0, mac_pkg::OFS_RES_LO, 16'h0006);
    rc(1'b0, mac_pkg::OFS_RES_HI, 16'h0000);
    rc(1'b0, mac_pkg::OFS_SUM_EXT, 16'h0000);
    u_cpu.idle();
  endtask : t_signed

  task automatic t_umac;
    u_cpu.wr(1'b0, mac_pkg::OFS_RES_LO, 16'hffff);
    u_cpu.wr(1'b0, mac_pkg::OFS_RES_HI, 16'hffff);
    u_cpu.wr(1'b0, mac_pkg::OFS_MAC, 16'h0001);
    u_cpu.wr(1'b0, mac_pkg::OFS_SECOND, 16'h0001);
    rc(1'b0, mac_pkg::OFS_RES_HI, 16'h0000);
    rc(1'b0, mac_pkg::OFS_SUM_EXT, 16'h0001);
    u_cpu.wr(1'b0, mac_pkg::OFS_SECOND, 16'h0001);
    rc(1'b0, mac_pkg::OFS_RES_LO, 16'h0001);
    rc(1'b0, mac_pkg::OFS_SUM_EXT, 16'h0000);
    u_cpu.idle();
  endtask : t_umac

  task automatic t_smac;
    u_cpu.wr(1'b0, mac_pkg::OFS_RES_LO, 16'hffff);
    u_cpu.wr(1'b0, mac_pkg::OFS_RES_HI, 16'h7fff);
    u_cpu.wr(1'b0, mac_pkg::OFS_SIGNED_ACCUMULATE_FIRST_OPERAND, 16'h0001);
    u_cpu.wr(1'b0, mac_pkg::OFS_SECOND, 16'h0001);
    rc(1'b0, mac_pkg::OFS_RES_HI, 16'h8000);
    rc(1'b0, mac_pkg::OFS_SUM_EXT, 16'hffff);
    u_cpu.wr(1'b0, mac_pkg::OFS_RES_LO, 16'h0000);
    u_cpu.wr(1'b0, mac_pkg::OFS_RES_HI, 16'h8000);
    u_cpu.wr(1'b0, mac_pkg::OFS_SECOND, 16'hffff);
    rc(1'b0, mac_pkg::OFS_RES_HI, 16'h7fff);
    rc(1'b0, mac_pkg::OFS_SUM_EXT, 16'h0000);
    u_cpu.idle();
  endtask : t_smac

  task automatic t_bytes;
    u_cpu.wr(1'b1, mac_pkg::OFS_MPY, 16'hab12);
    rc(1'b0, mac_pkg::OFS_SIGNED_ACCUMULATE_FIRST_OPERAND, 16'h0012);
    u_cpu.wr(1'b1, mac_pkg::OFS_SECOND, 16'hcd34);
    rc(1'b0, mac_pkg::OFS_SECOND, 16'h0034);
    rc(1'b1, mac_pkg::OFS_RES_LO, 16'h00a8);
    rc(1'b1, 16'h013b, 16'h0003);
    // odd byte write replaces the high byte and triggers again
    u_cpu.wr(1'b1, 16'h0139, 16'h0012);
    rc(1'b0, mac_pkg::OFS_RES_LO, 16'h47a8);
    rc(1'b0, mac_pkg::OFS_RES_HI, 16'h0001);
    u_cpu.wr(1'b1, mac_pkg::OFS_RES_HI, 16'h55ff);
    rc(1'b0, mac_pkg::OFS_RES_HI, 16'h00ff);
    u_cpu.wr(1'b0, mac_pkg::OFS_SUM_EXT, 16'h1234);
    rc(1'b0, mac_pkg::OFS_SUM_EXT, 16'h0000);
    rc(1'b0, 16'h0200, 16'h0000);
    u_cpu.idle();
  endtask : t_bytes

  task automatic t_reset_keep;
    u_cpu.wr(1'b0, mac_pkg::OFS_MPY, 16'h5a5a);
    u_cpu.idle();
    sys_rst <= 1'b1;
    repeat (2) @(negedge mclk);
    sys_rst <= 1'b0;
    rc(1'b0, mac_pkg::OFS_MPY, 16'h5a5a);
    u_cpu.idle();
  endtask : t_reset_keep

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    n_errors    = 0;
    check_count = 0;
    cycles      = 0;
    sys_rst     = 1'b1;
    repeat (16) @(negedge mclk);
    sys_rst <= 1'b0;
    t_unsigned();
    t_signed();
    t_umac();
    t_smac();
    t_bytes();
    t_reset_keep();
    final_report();
  end
endmodule : memory_mapped_multiply_accumulate_tb_top
